// ---- pic_ctrl_bank.sv ----
// Per-port ingress classification and egress tagging control register bank
`default_nettype none
module pic_ctrl_bank
   import pic_pkg::*;
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rstn,
   // Management register port
   input  wire logic [PIC_AW-1:0]   reg_addr,
   input  wire logic                reg_wr,
   input  wire logic [PIC_DW-1:0]   reg_wdata,
   input  wire logic                reg_rd,
   output logic [PIC_DW-1:0]        reg_rdata,
   output logic                     reg_rvalid,
   // Global settings held elsewhere
   input  wire logic [15:0]         tag_priority_map_entry,
   input  wire logic [PIC_NPORT-1:0] split2_en,
   input  wire logic [PIC_VIDW-1:0] port_default_vlan_id [PIC_NPORT],
   // Ingress frame descriptors, per port
   input  wire logic                rx_tagged    [PIC_NPORT],
   input  wire logic [2:0]          rx_pcp       [PIC_NPORT],
   input  wire logic                rx_dscp_hit  [PIC_NPORT],
   input  wire logic [1:0]          rx_dscp_prio [PIC_NPORT],
   // Egress frame descriptors, per port
   input  wire logic                tx_was_tagged [PIC_NPORT],
   input  wire logic [1:0]          tx_src_port   [PIC_NPORT],
   // Per-port decisions
   output logic [1:0]               rx_class_prio [PIC_NPORT],
   output logic [PIC_NPORT-1:0]     storm_protect_en,
   output logic [PIC_NPORT-1:0]     tx_tag_insert,
   output logic [PIC_NPORT-1:0]     tx_tag_strip,
   output logic [PIC_VIDW-1:0]      tx_insert_vid [PIC_NPORT],
   output pic_qmode_e               egress_frame_queue [PIC_NPORT]
);
   logic [PIC_DW-1:0]   ctrl [PIC_NPORT];
   logic [1:0]          p_prio   [PIC_NPORT];
   logic                p_storm  [PIC_NPORT];
   logic                p_ins    [PIC_NPORT];
   logic                p_strip  [PIC_NPORT];
   pic_qmode_e          p_qmode  [PIC_NPORT];
   logic [PIC_DW-1:0]   next_rdata;

   // Register writes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl[0] <= PIC_CTRL_RST;
         ctrl[1] <= PIC_CTRL_RST;
         ctrl[2] <= PIC_CTRL_RST;
      end else if (reg_wr) begin
         if (reg_addr == PIC_OFS_P1) begin
            ctrl[0] <= reg_wdata;
         end else if (reg_addr == PIC_OFS_P2) begin
            ctrl[1] <= reg_wdata;
         end else if (reg_addr == PIC_OFS_P3) begin
            ctrl[2] <= reg_wdata;
         end
      end
   end

   // Read mux; unmapped addresses return zero
   always_comb begin
      if (reg_addr == PIC_OFS_P1) begin
         next_rdata = ctrl[0];
      end else if (reg_addr == PIC_OFS_P2) begin
         next_rdata = ctrl[1];
      end else if (reg_addr == PIC_OFS_P3) begin
         next_rdata = ctrl[2];
      end else begin
         next_rdata = PIC_CTRL_RST;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata  <= PIC_CTRL_RST;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   for (genvar p = 0; p < PIC_NPORT; p++) begin : g_port
      pic_port_path pic_port_path_i (
         .ctrl                   (ctrl[p]),
         .split2                 (split2_en[p]),
         .tag_priority_map_entry (tag_priority_map_entry),
         .rx_tagged              (rx_tagged[p]),
         .rx_pcp                 (rx_pcp[p]),
         .rx_dscp_hit            (rx_dscp_hit[p]),
         .rx_dscp_prio           (rx_dscp_prio[p]),
         .tx_was_tagged          (tx_was_tagged[p]),
         .class_prio             (p_prio[p]),
         .storm_en               (p_storm[p]),
         .tag_insert             (p_ins[p]),
         .tag_strip              (p_strip[p]),
         .qmode                  (p_qmode[p])
      );

      // Decisions registered so every output comes from a flop
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            rx_class_prio[p]      <= 2'h0;
            storm_protect_en[p]   <= 1'b0;
            tx_tag_insert[p]      <= 1'b0;
            tx_tag_strip[p]       <= 1'b0;
            tx_insert_vid[p]      <= '0;
            egress_frame_queue[p] <= PIC_Q_ONE;
         end else begin
            rx_class_prio[p]      <= p_prio[p];
            storm_protect_en[p]   <= p_storm[p];
            tx_tag_insert[p]      <= p_ins[p];
            tx_tag_strip[p]       <= p_strip[p];
            egress_frame_queue[p] <= p_qmode[p];
            // Out-of-range source index 3 falls back to port_default_vlan_id[0]
            if (tx_src_port[p] == 2'h1) begin
               tx_insert_vid[p] <= port_default_vlan_id[1];
            end else if (tx_src_port[p] == 2'h2) begin
               tx_insert_vid[p] <= port_default_vlan_id[2];
            end else begin
               tx_insert_vid[p] <= port_default_vlan_id[0];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- pic_ctrl_bank_props.sv ----
// Assertions on the control bank ports
`default_nettype none
module pic_ctrl_bank_props
   import pic_pkg::*;
(
   // Register port
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rvalid,
   // Per-port paths
   input wire logic [2:0]  split2_en,
   input wire logic [11:0] port_default_vlan_id [3],
   input wire logic        tx_was_tagged [3],
   input wire logic [1:0]  tx_src_port [3],
   input wire logic [2:0]  storm_protect_en,
   input wire logic [2:0]  tx_tag_insert,
   input wire logic [2:0]  tx_tag_strip,
   input wire logic [11:0] tx_insert_vid [3],
   input wire pic_qmode_e  egress_frame_queue [3]
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_wr_p1;
      reg_wr && reg_addr == PIC_OFS_P1;
   endsequence
   sequence s_rd_p1;
      reg_rd && !reg_wr && reg_addr == PIC_OFS_P1;
   endsequence
   a_rd_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("stray read valid");
   a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {8'h10, 8'h20, 8'h30})
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_write_back: assert property (s_wr_p1 ##1 (!reg_wr && !reg_rd) ##1 s_rd_p1
      |=> reg_rdata == $past(reg_wdata, 3)) else $error("read back differs");
   a_storm_bit: assert property (s_wr_p1 ##1 !reg_wr
      |=> storm_protect_en[0] == $past(reg_wdata[7], 2)) else $error("storm enable wrong");
   a_insert_untag: assert property (tx_tag_insert[1] |-> !$past(tx_was_tagged[1]))
      else $error("tag added to tagged frame");
   a_strip_tagged: assert property (tx_tag_strip[2] |-> $past(tx_was_tagged[2]))
      else $error("strip on untagged frame");
   a_vid_source: assert property (tx_tag_insert[0] |-> tx_insert_vid[0] ==
      $past(port_default_vlan_id[tx_src_port[0] == 2'h3 ? 0 : tx_src_port[0]]))
      else $error("inserted vid wrong");
   a_two_queue: assert property (egress_frame_queue[1] == PIC_Q_TWO
      |-> $past(split2_en[1])) else $error("two queues without split");
endmodule
bind pic_ctrl_bank pic_ctrl_bank_props pic_ctrl_bank_props_i (.clk, .rstn, .reg_addr, .reg_wr,
   .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .split2_en, .port_default_vlan_id,
   .tx_was_tagged, .tx_src_port, .storm_protect_en, .tx_tag_insert, .tx_tag_strip,
   .tx_insert_vid, .egress_frame_queue);
`default_nettype wire

// ---- pic_ctrl_bank_test.sv ----
// Corner and random tests for the control bank
`default_nettype none
module pic_ctrl_bank_test
   import pic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] OFS [3] = '{PIC_OFS_P1, PIC_OFS_P2, PIC_OFS_P3};
   localparam logic [7:0] COR [6] = '{8'h60, 8'h78, 8'h06, 8'h01, 8'hff, 8'h9a};
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic [7:0]  reg_rdata;
   logic        reg_rvalid;
   logic [15:0] map = 16'h0000;
   logic [2:0]  split2_en = 3'h0;
   logic [2:0]  storm, ins, strp;
   logic [11:0] vid [3] = '{default: 12'h000};
   logic [11:0] ivid [3];
   logic        tagd [3] = '{default: 1'b0};
   logic        dhit [3] = '{default: 1'b0};
   logic        wtag [3] = '{default: 1'b0};
   logic [2:0]  pcp [3] = '{default: 3'h0};
   logic [1:0]  dpri [3] = '{default: 2'h0};
   logic [1:0]  src [3] = '{default: 2'h0};
   logic [1:0]  prio [3];
   logic [7:0]  ctl [3] = '{default: 8'h00};
   pic_qmode_e  q [3];
   int          error_cnt = 0;
   int          n_checks = 0;
   always #10 clk = ~clk;
   pic_ctrl_bank pic_ctrl_bank_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .tag_priority_map_entry(map), .split2_en(split2_en), .port_default_vlan_id(vid),
      .rx_tagged(tagd), .rx_pcp(pcp), .rx_dscp_hit(dhit), .rx_dscp_prio(dpri),
      .tx_was_tagged(wtag), .tx_src_port(src), .rx_class_prio(prio), .storm_protect_en(storm),
      .tx_tag_insert(ins), .tx_tag_strip(strp), .tx_insert_vid(ivid), .egress_frame_queue(q));
   task automatic chk(input string what, input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [1:0] exp_prio(input int p);
      logic       th;
      logic       dh;
      logic [1:0] tp;
      th = ctl[p][5] & tagd[p];
      dh = ctl[p][6] & dhit[p];
      tp = map[2*pcp[p] +: 2];
      if (th && dh)
         return tp | dpri[p];
      if (th)
         return tp;
      return dh ? dpri[p] : ctl[p][4:3];
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      foreach (ctl[p])
         if (a == OFS[p])
            ctl[p] = d;
   endtask
   task automatic rd(input logic [7:0] a);
      logic [7:0] e;
      e = 8'h00;
      foreach (ctl[p])
         if (a == OFS[p])
            e = ctl[p];
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rvalid", 12'(reg_rvalid), 12'h001);
      chk("reg_rdata", 12'(reg_rdata), 12'(e));
   endtask
   task automatic shuffle();
      @(posedge clk);
      map <= 16'($urandom);
      for (int p = 0; p < 3; p++) begin
         tagd[p] <= 1'($urandom);
         pcp[p] <= 3'($urandom);
         dhit[p] <= 1'($urandom);
         dpri[p] <= 2'($urandom);
         wtag[p] <= 1'($urandom);
         src[p] <= 2'($urandom);
         vid[p] <= 12'($urandom);
         split2_en[p] <= ~ctl[p][0] & 1'($urandom);
      end
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic check_paths();
      for (int p = 0; p < 3; p++) begin
         chk("class_prio", 12'(prio[p]), 12'(exp_prio(p)));
         chk("storm", 12'(storm[p]), 12'(ctl[p][7]));
         chk("insert", 12'(ins[p]), 12'(ctl[p][2] & ~wtag[p]));
         chk("strip", 12'(strp[p]), 12'(ctl[p][1] & wtag[p]));
         chk("queue", 12'(q[p]), ctl[p][0] ? 12'h3 : 12'(split2_en[p]));
         if (ins[p] === 1'b1)
            chk("vid", ivid[p], vid[src[p] == 2'h3 ? 0 : src[p]]);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      logic [7:0] d;
      void'($urandom(32'h0572));
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      for (int p = 0; p < 3; p++)
         rd(OFS[p]);
      check_paths();
      // Unmapped places hold nothing
      wr(8'h40, 8'hff);
      rd(8'h40);
      rd(8'h11);
      for (int i = 0; i < 168; i++) begin
         d = i < 18 ? COR[i / 3] : 8'($urandom);
         if (split2_en[i % 3])
            d[0] = 1'b0;
         wr(OFS[i % 3], d);
         rd(OFS[i % 3]);
         shuffle();
         check_paths();
      end
      // Reset in mid-run must clear every copy again
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      ctl = '{default: 8'h00};
      for (int p = 0; p < 3; p++)
         rd(OFS[p]);
      check_paths();
      close_out();
   end
   // Run needs about 1200 cycles
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      close_out();
   end
endmodule
`default_nettype wire

// ---- pic_pkg.sv ----
// Shared constants for the per-port ingress class and egress tag control bank
`default_nettype none
package pic_pkg;
   localparam int          PIC_NPORT     = 3;
   localparam int          PIC_AW        = 8;
   localparam int          PIC_DW        = 8;
   localparam int          PIC_VIDW      = 12;
   // Register offsets, port 1..3
   localparam logic [7:0]  PIC_OFS_P1    = 8'h10;
   localparam logic [7:0]  PIC_OFS_P2    = 8'h20;
   localparam logic [7:0]  PIC_OFS_P3    = 8'h30;
   localparam logic [7:0]  PIC_CTRL_RST  = 8'h00;
   // Field positions
   localparam int          PIC_B_STORM   = 7;
   localparam int          PIC_B_DSCP    = 6;
   localparam int          PIC_B_TAGPRI  = 5;
   localparam int          PIC_B_PRI_HI  = 4;
   localparam int          PIC_B_PRI_LO  = 3;
   localparam int          PIC_B_INSERT  = 2;
   localparam int          PIC_B_STRIP   = 1;
   localparam int          PIC_B_SPLIT4  = 0;
   // Transmit queue arrangement
   typedef enum logic [1:0] {
      PIC_Q_ONE  = 2'h0,
      PIC_Q_TWO  = 2'h1,
      PIC_Q_FOUR = 2'h3
   } pic_qmode_e;
endpackage
`default_nettype wire

// ---- pic_port_path.sv ----
// Per-port classification and egress tag decision from one control byte
`default_nettype none
module pic_port_path
   import pic_pkg::*;
(
   // Configuration
   input  wire logic [PIC_DW-1:0]   ctrl,
   input  wire logic                split2,
   input  wire logic [15:0]         tag_priority_map_entry,
   // Ingress frame on this port
   input  wire logic                rx_tagged,
   input  wire logic [2:0]          rx_pcp,
   input  wire logic                rx_dscp_hit,
   input  wire logic [1:0]          rx_dscp_prio,
   // Egress frame on this port
   input  wire logic                tx_was_tagged,
   // Decisions
   output logic [1:0]               class_prio,
   output logic                     storm_en,
   output logic                     tag_insert,
   output logic                     tag_strip,
   output pic_qmode_e               qmode
);
   logic       tag_hit;
   logic       dscp_hit;
   logic [1:0] tag_prio;

   assign tag_prio = tag_priority_map_entry[{rx_pcp, 1'b0} +: 2];
   assign tag_hit  = ctrl[PIC_B_TAGPRI] && rx_tagged;
   assign dscp_hit = ctrl[PIC_B_DSCP] && rx_dscp_hit;

   always_comb begin
      if (tag_hit && dscp_hit) begin
         class_prio = tag_prio | rx_dscp_prio;
      end else if (tag_hit) begin
         class_prio = tag_prio;
      end else if (dscp_hit) begin
         class_prio = rx_dscp_prio;
      end else begin
         class_prio = ctrl[PIC_B_PRI_HI:PIC_B_PRI_LO];
      end
   end

   assign storm_en   = ctrl[PIC_B_STORM];
   // Tagged frames never get a second tag, untagged ones are never stripped
   assign tag_insert = ctrl[PIC_B_INSERT] && !tx_was_tagged;
   assign tag_strip  = ctrl[PIC_B_STRIP] && tx_was_tagged;

   // Both splits set is illegal; four queues wins so the result stays defined
   always_comb begin
      if (ctrl[PIC_B_SPLIT4]) begin
         qmode = PIC_Q_FOUR;
      end else if (split2) begin
         qmode = PIC_Q_TWO;
      end else begin
         qmode = PIC_Q_ONE;
      end
   end
endmodule
`default_nettype wire
